// ==== hdl/pmg_byte_mem.sv ====
// 128 x 8 byte memory, one synchronous write port and one combinational read port
`timescale 1ns/100ps
module pmg_byte_mem (
  // Clock
  input wire logic core_clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:127];

  // Contents are not reset; owners track validity themselves
  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Unregistered read keeps the bus answer to one wait state
  assign rdata_o = mem[raddr_i];
endmodule : pmg_byte_mem

// ==== hdl/pmg_gateway.sv ====
// Parameter memory gateway with burst access, keyed burn and reload, on APB
//
// Overview of operation
// (RULE1) Write bursts accepted in every operating mode
// (RULE2) Host moves data in eight-byte bursts
// (RULE3) Write burst: gateway on, direction zero
// (RULE4) Host then writes eight-aligned window base
// (RULE5) Window bytes 0-7 land at base+offset
// (RULE6) Host ends burst writing zero to 5:3
// (RULE7) Sixteen bursts cover whole memory
// (RULE8) Host waits interrupt, or 30 ms asleep
// (RULE9) Applied burst sets bit 5, interrupt
// (RULE10) Sleep: delayed apply, no completion interrupt
// (RULE11) Reading interrupt source clears bit 5
// (RULE12) Read burst: gateway on, direction one
// (RULE13) Read burst returns base+0 to base+7
// (RULE14) Burn only complete data, three effective
// (RULE15) Host burns only in Active or Doze
// (RULE16) Burn completion sets bit 6, interrupt
// (RULE17) After reset, stored parameters reload shadow
// (RULE18) Burn count readable in status 2:0
// (RULE19) Initially zero count, factory defaults loaded
// (RULE20) Burns count up; fourth forces factory
// (RULE21) Host writes both burn keys first
// (RULE22) Burn starts after A5 then 5A
// (RULE23) Mode 01 on, others off
// (RULE24) Status bit 3 flags stored validity
// (RULE25) Burst bytes held, committed atomically
`timescale 1ns/100ps
module pmg_gateway
  import pmg_pkg::*;
#(
  parameter int unsigned SLEEP_APPLY_CYC = PMG_SLEEP_APPLY_CYC
) (
  // Clock and resets
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic factory_restore_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt pin, active low
  output logic interrupt_out_n_o
);
  pmg_state_t state;
  logic [6:0] cnt;
  logic [31:0] dly;
  logic sleep_apply;
  logic [1:0] gw_mode;
  logic gw_read;
  logic [3:0] base_slot;
  logic [1:0] op_mode;
  logic [7:0] hold [0:7];
  logic hold_dirty;
  logic commit_req;
  logic burn_req;
  logic [1:0] key_step;
  logic [2:0] burn_counter;
  logic stored_params_valid;
  logic irq_write;
  logic irq_burn;
  logic [7:0] idx;
  logic addr_ok;
  logic acc;
  logic fire;
  logic wr;
  logic [7:0] wbyte;
  logic gw_on;
  logic set_write;
  logic set_burn;
  logic clr_irq;
  logic next_irq_write;
  logic next_irq_burn;
  logic sh_we;
  logic [6:0] sh_waddr;
  logic [7:0] sh_wdata;
  logic [6:0] sh_raddr;
  logic [7:0] sh_rdata;
  logic [7:0] nv_rdata;
  logic [31:0] rd_mux;

  // Bus decode; one wait state, effects only at the completing edge
  assign idx = paddr_i[9:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0) &&
    ((idx[7:3] == 5'h00) || (idx == PMG_IDX_STATUS) || (idx == PMG_IDX_OPMODE) ||
     (idx == PMG_IDX_CONFIG) || (idx == PMG_IDX_BASE) || (idx == PMG_IDX_IRQ) ||
     (idx == PMG_IDX_KEYH) || (idx == PMG_IDX_KEYL));
  assign acc = psel_i && penable_i && !pready_o;
  assign fire = psel_i && penable_i && pready_o;
  assign wr = fire && pwrite_i && addr_ok;
  assign wbyte = pwdata_i[7:0];
  // (RULE23) only code 01 opens gateway
  assign gw_on = (gw_mode == PMG_GW_ON);

  // Shadow and stored parameter memories
  pmg_byte_mem u_shadow (
    .core_clk_i(core_clk_i),
    .we_i(sh_we),
    .waddr_i(sh_waddr),
    .wdata_i(sh_wdata),
    .raddr_i(sh_raddr),
    .rdata_o(sh_rdata)
  );
  pmg_byte_mem u_stored (
    .core_clk_i(core_clk_i),
    .we_i(state == PMG_BURN),
    .waddr_i(cnt),
    .wdata_i(sh_rdata),
    .raddr_i(cnt),
    .rdata_o(nv_rdata)
  );

  // Shadow write source follows the engine state
  always_comb
  begin
    sh_we = 1'b0;
    sh_waddr = cnt;
    sh_wdata = 8'h00;
    sh_raddr = {base_slot, idx[2:0]};
    if (state == PMG_LOAD)
    begin
      sh_we = 1'b1;
      // (RULE24) invalid store falls back to factory
      sh_wdata = stored_params_valid ? nv_rdata : pmg_factory_byte(cnt);
    end
    else if (state == PMG_COMMIT)
    begin
      // (RULE5) byte lands at base plus offset
      sh_we = 1'b1;
      sh_waddr = {base_slot, cnt[2:0]};
      sh_wdata = hold[cnt[2:0]];
    end
    else if (state == PMG_BURN)
    begin
      sh_raddr = cnt;
    end
  end

  // APB handshake and read data; status and bus error registered
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= acc;
      pslverr_o <= acc && !addr_ok;
      if (acc && !pwrite_i)
      begin
        prdata_o <= addr_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Read mux; reserved bits read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (idx[7:3] == 5'h00)
    begin
      // (RULE13) read burst returns shadow bytes
      rd_mux[7:0] = (gw_on && gw_read) ? sh_rdata : hold[idx[2:0]];
    end
    else if (idx == PMG_IDX_STATUS)
    begin
      // (RULE18) count and validity visible
      rd_mux[3:0] = {stored_params_valid, burn_counter};
    end
    else if (idx == PMG_IDX_OPMODE)
    begin
      rd_mux[1:0] = op_mode;
    end
    else if (idx == PMG_IDX_CONFIG)
    begin
      rd_mux[5:3] = {gw_mode, gw_read};
    end
    else if (idx == PMG_IDX_BASE)
    begin
      rd_mux[7:0] = {1'b0, base_slot, 3'h0};
    end
    else if (idx == PMG_IDX_IRQ)
    begin
      rd_mux[PMG_IRQ_BURN_BIT] = irq_burn;
      rd_mux[PMG_IRQ_WRITE_BIT] = irq_write;
    end
  end

  // Configuration, window base and operating mode registers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      gw_mode <= PMG_GW_OFF;
      gw_read <= 1'b0;
      base_slot <= 4'h0;
      op_mode <= PMG_OP_ACTIVE;
    end
    else if (wr)
    begin
      if (idx == PMG_IDX_CONFIG)
      begin
        gw_mode <= wbyte[PMG_CFG_MODE_LSB +: 2];
        gw_read <= wbyte[PMG_CFG_DIR_BIT];
      end
      if (idx == PMG_IDX_BASE)
      begin
        // Low three bits dropped so the base is always eight-aligned
        base_slot <= wbyte[6:3];
      end
      if (idx == PMG_IDX_OPMODE)
      begin
        op_mode <= wbyte[1:0];
      end
    end
  end

  // Burst holding registers, one per window byte
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_hold
      always_ff @(posedge core_clk_i)
      begin
        if (srst_i)
        begin
          hold[g] <= 8'h00;
        end
        // (RULE1) accepted whatever the operating mode
        else if (wr && (idx == 8'(g)) && gw_on && !gw_read)
        begin
          hold[g] <= wbyte;
        end
      end
    end
  endgenerate

  // Commit request raised by the terminating configuration write
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      hold_dirty <= 1'b0;
      commit_req <= 1'b0;
    end
    else
    begin
      // (RULE25) commit only on closing write
      if (wr && (idx == PMG_IDX_CONFIG) && gw_on && !gw_read && hold_dirty &&
          (wbyte[PMG_CFG_MODE_LSB +: 2] != PMG_GW_ON))
      begin
        commit_req <= 1'b1;
        hold_dirty <= 1'b0;
      end
      else if (wr && (idx[7:3] == 5'h00) && gw_on && !gw_read)
      begin
        hold_dirty <= 1'b1;
      end
      if ((state == PMG_IDLE) && commit_req)
      begin
        commit_req <= 1'b0;
      end
    end
  end

  // Burn unlock tracker; any other write to a mapped register breaks the sequence
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      key_step <= 2'h0;
      burn_req <= 1'b0;
    end
    else
    begin
      if (wr)
      begin
        key_step <= 2'h0;
        if ((idx == PMG_IDX_KEYH) && (wbyte == PMG_KEY_HIGH))
        begin
          key_step <= 2'h1;
        end
        else if ((idx == PMG_IDX_KEYL) && (wbyte == PMG_KEY_LOW) && (key_step == 2'h1))
        begin
          key_step <= 2'h2;
        end
        else if ((idx == PMG_IDX_BASE) && (wbyte == PMG_BURN_ARM) && (key_step == 2'h2))
        begin
          key_step <= 2'h3;
        end
        // (RULE22) full four-write sequence starts burn
        else if ((idx == PMG_IDX_BASE) && (wbyte == PMG_BURN_GO) && (key_step == 2'h3))
        begin
          burn_req <= 1'b1;
        end
      end
      if ((state == PMG_IDLE) && !commit_req && burn_req)
      begin
        burn_req <= 1'b0;
      end
    end
  end

  // Engine: reload, burst commit, sleep delay and burn
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      // (RULE17) every functional reset reloads the shadow
      state <= PMG_LOAD;
      cnt <= 7'h00;
      dly <= 32'h0000_0000;
      sleep_apply <= 1'b0;
    end
    else
    begin
      unique case (state)
        PMG_IDLE:
        begin
          cnt <= 7'h00;
          dly <= 32'h0000_0000;
          if (commit_req)
          begin
            sleep_apply <= (op_mode == PMG_OP_SLEEP);
            state <= (op_mode == PMG_OP_SLEEP) ? PMG_SLEEP_WAIT : PMG_COMMIT;
          end
          else if (burn_req)
          begin
            state <= PMG_BURN;
          end
        end
        PMG_LOAD,
        PMG_BURN:
        begin
          cnt <= cnt + 7'h01;
          if (cnt == PMG_MEM_LAST)
          begin
            state <= PMG_IDLE;
          end
        end
        PMG_SLEEP_WAIT:
        begin
          // (RULE10) sleep apply is deferred
          dly <= dly + 32'h0000_0001;
          if (dly >= SLEEP_APPLY_CYC - 1)
          begin
            state <= PMG_COMMIT;
          end
        end
        PMG_COMMIT:
        begin
          cnt <= cnt + 7'h01;
          if (cnt[2:0] == PMG_BURST_LAST)
          begin
            state <= PMG_IDLE;
          end
        end
      endcase
    end
  end

  // Burn counter and validity survive the functional reset
  always_ff @(posedge core_clk_i)
  begin
    if (factory_restore_i)
    begin
      // (RULE19) fresh part: zero count, factory
      burn_counter <= 3'h0;
      stored_params_valid <= 1'b0;
    end
    else if (set_burn)
    begin
      // (RULE20) count up, fourth burn forces factory
      if (burn_counter != PMG_BURN_LIMIT)
      begin
        burn_counter <= burn_counter + 3'h1;
      end
      stored_params_valid <= (burn_counter < PMG_BURN_LIMIT - 3'h1);
    end
  end

  // Interrupt sources: a set in the clearing cycle wins
  assign set_write = (state == PMG_COMMIT) && (cnt[2:0] == PMG_BURST_LAST) && !sleep_apply;
  assign set_burn = (state == PMG_BURN) && (cnt == PMG_MEM_LAST);
  assign clr_irq = fire && !pwrite_i && (idx == PMG_IDX_IRQ);
  // (RULE11) reading source register clears it
  assign next_irq_write = (irq_write && !clr_irq) || set_write;
  assign next_irq_burn = (irq_burn && !clr_irq) || set_burn;

  // Sticky bits and the pin come from flops, pin low while any bit set
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      irq_write <= 1'b0;
      irq_burn <= 1'b0;
      interrupt_out_n_o <= 1'b1;
    end
    else
    begin
      // (RULE9) applied burst flags completion
      irq_write <= next_irq_write;
      // (RULE16) finished burn flags completion
      irq_burn <= next_irq_burn;
      interrupt_out_n_o <= !(next_irq_write || next_irq_burn);
    end
  end

  // Assertions
  property p_pin_tracks;
    @(posedge core_clk_i) disable iff (srst_i)
    interrupt_out_n_o == !(irq_write || irq_burn);
  endproperty
  a_pin_tracks: assert property (p_pin_tracks) else $error("pin disagrees"); // (RULE9)
  property p_commit_irq;
    @(posedge core_clk_i) disable iff (srst_i)
    (state == PMG_COMMIT) && (cnt[2:0] == PMG_BURST_LAST) && !sleep_apply |=>
      irq_write && !interrupt_out_n_o && (state == PMG_IDLE);
  endproperty
  a_commit_irq: assert property (p_commit_irq) else $error("no write irq"); // (RULE9)
  property p_sleep_quiet;
    @(posedge core_clk_i) disable iff (srst_i)
    (state == PMG_SLEEP_WAIT) ##1 (state == PMG_COMMIT) |-> ##8 !$rose(irq_write);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep irq"); // (RULE10)
  property p_read_clears;
    @(posedge core_clk_i) disable iff (srst_i)
    clr_irq && !set_write |=> !irq_write;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("not cleared"); // (RULE11)
  property p_status_read;
    @(posedge core_clk_i) disable iff (srst_i)
    acc && !pwrite_i && (idx == PMG_IDX_STATUS) |=>
      prdata_o[3:0] == {$past(stored_params_valid), $past(burn_counter)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("bad status"); // (RULE18)
  property p_burn_done;
    @(posedge core_clk_i) disable iff (srst_i)
    set_burn && (burn_counter < PMG_BURN_LIMIT) |=>
      irq_burn && (burn_counter == $past(burn_counter) + 3'h1);
  endproperty
  a_burn_done: assert property (p_burn_done) else $error("burn end"); // (RULE16)
  property p_fourth_burn;
    @(posedge core_clk_i) disable iff (srst_i)
    set_burn && (burn_counter == PMG_BURN_LIMIT - 3'h1) |=>
      !stored_params_valid && (burn_counter == PMG_BURN_LIMIT);
  endproperty
  a_fourth_burn: assert property (p_fourth_burn) else $error("no fallback"); // (RULE20)
  property p_reset_load;
    @(posedge core_clk_i) disable iff (srst_i)
    $past(srst_i) |-> (state == PMG_LOAD) && (cnt == 7'h00);
  endproperty
  a_reset_load: assert property (p_reset_load) else $error("no reload"); // (RULE17)
  property p_factory_src;
    @(posedge core_clk_i) disable iff (srst_i)
    (state == PMG_LOAD) && !stored_params_valid |-> sh_wdata == pmg_factory_byte(cnt);
  endproperty
  a_factory_src: assert property (p_factory_src) else $error("bad source"); // (RULE24)
  property p_commit_map;
    @(posedge core_clk_i) disable iff (srst_i)
    (state == PMG_COMMIT) |-> sh_we && (sh_waddr[2:0] == cnt[2:0]) && (sh_waddr[6:3] == base_slot);
  endproperty
  a_commit_map: assert property (p_commit_map) else $error("bad map"); // (RULE5)
  property p_burn_start;
    @(posedge core_clk_i) disable iff (srst_i)
    wr && (idx == PMG_IDX_BASE) && (wbyte == PMG_BURN_GO) && (key_step == 2'h3) |=> burn_req;
  endproperty
  a_burn_start: assert property (p_burn_start) else $error("burn missed"); // (RULE22)
  property p_win_read;
    @(posedge core_clk_i) disable iff (srst_i)
    acc && !pwrite_i && (idx[7:3] == 5'h00) && gw_on && gw_read |=>
      prdata_o[7:0] == $past(sh_rdata);
  endproperty
  a_win_read: assert property (p_win_read) else $error("bad window"); // (RULE13)
  c_commit: cover property (@(posedge core_clk_i) disable iff (srst_i) set_write);
  c_burn: cover property (@(posedge core_clk_i) disable iff (srst_i) set_burn);
  c_sleep: cover property (@(posedge core_clk_i) disable iff (srst_i) state == PMG_SLEEP_WAIT);
  c_clear: cover property (@(posedge core_clk_i) disable iff (srst_i) clr_irq && irq_write);
endmodule : pmg_gateway

// ==== hdl/pmg_pkg.sv ====
// Package: register map, field layout, keys and timing for the parameter gateway
package pmg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] PMG_IDX_WIN0 = 8'h00;
  localparam logic [7:0] PMG_IDX_STATUS = 8'h08;
  localparam logic [7:0] PMG_IDX_OPMODE = 8'h09;
  localparam logic [7:0] PMG_IDX_CONFIG = 8'h0D;
  localparam logic [7:0] PMG_IDX_BASE = 8'h0E;
  localparam logic [7:0] PMG_IDX_IRQ = 8'h40;
  localparam logic [7:0] PMG_IDX_KEYH = 8'hAC;
  localparam logic [7:0] PMG_IDX_KEYL = 8'hAD;
  // Field positions
  localparam int PMG_CFG_MODE_LSB = 4;
  localparam int PMG_CFG_DIR_BIT = 3;
  localparam int PMG_IRQ_WRITE_BIT = 5;
  localparam int PMG_IRQ_BURN_BIT = 6;
  localparam int PMG_STAT_VALID_BIT = 3;
  // Field codes and reset values
  localparam logic [1:0] PMG_GW_OFF = 2'h0;
  localparam logic [1:0] PMG_GW_ON = 2'h1;
  localparam logic [1:0] PMG_OP_ACTIVE = 2'h0;
  localparam logic [1:0] PMG_OP_SLEEP = 2'h2;
  localparam logic [2:0] PMG_BURN_LIMIT = 3'h4;
  // Burn unlock sequence values
  localparam logic [7:0] PMG_KEY_HIGH = 8'h62;
  localparam logic [7:0] PMG_KEY_LOW = 8'h9D;
  localparam logic [7:0] PMG_BURN_ARM = 8'hA5;
  localparam logic [7:0] PMG_BURN_GO = 8'h5A;
  // Memory geometry
  localparam logic [6:0] PMG_MEM_LAST = 7'h7F;
  localparam logic [2:0] PMG_BURST_LAST = 3'h7;
  // Sleep-mode apply delay
  localparam int PMG_CLK_MHZ = 125;
  localparam int PMG_SLEEP_APPLY_MS = 30;
  localparam int PMG_SLEEP_APPLY_CYC = PMG_SLEEP_APPLY_MS * 1000 * PMG_CLK_MHZ;
  // Engine states, Gray along load, idle, sleep wait, commit path
  typedef enum logic [2:0] {
    PMG_LOAD = 3'h1,
    PMG_IDLE = 3'h0,
    PMG_SLEEP_WAIT = 3'h2,
    PMG_COMMIT = 3'h3,
    PMG_BURN = 3'h6
  } pmg_state_t;
  // Factory default contents, an arbitrary fixed pattern
  function automatic logic [7:0] pmg_factory_byte(input logic [6:0] addr);
    pmg_factory_byte = {1'b0, addr} ^ 8'h5A;
  endfunction : pmg_factory_byte
endpackage : pmg_pkg

// ==== tb/pmg_apb_host.sv ====
// APB host model standing in for the bus controller that drives the gateway
`timescale 1ns/100ps
module pmg_apb_host
  import pmg_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // APB master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  // Interrupt pin of the device
  input wire logic interrupt_out_n_i
);
  // Bus idle from time zero so no strobe starts unknown
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end

  // One transfer; request held until pready is sampled high, no fixed wait assumed
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= {2'b00, idx, 2'b00};
    pwdata_o <= {24'h00_0000, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1)
      @(posedge clk_i);
    q = prdata_i[7:0];
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer

  // Single register write, answer ignored
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic err;
    xfer(1'b1, idx, d, q, err);
  endtask : wr

  // Single register read
  task automatic rd(input logic [7:0] idx, output logic [7:0] q, output logic err);
    xfer(1'b0, idx, 8'h00, q, err);
  endtask : rd

  // Write burst; gm lets a scenario try a reserved gateway code
  task automatic write_burst(input logic [6:0] base, input logic [63:0] d,
                             input logic [1:0] gm);
    wr(PMG_IDX_CONFIG, {2'b00, gm, 4'h0});
    wr(PMG_IDX_BASE, {1'b0, base[6:3], 3'b000});
    for (int i = 0; i < 8; i++)
      wr(PMG_IDX_WIN0 + 8'(i), d[8*i+:8]);
    wr(PMG_IDX_CONFIG, 8'h00);
  endtask : write_burst

  // Read burst of eight bytes
  task automatic read_burst(input logic [6:0] base, output logic [63:0] q);
    logic [7:0] b;
    logic err;
    // gateway on, read direction, then base
    wr(PMG_IDX_CONFIG, 8'h18);
    wr(PMG_IDX_BASE, {1'b0, base[6:3], 3'b000});
    for (int i = 0; i < 8; i++)
    begin
      rd(PMG_IDX_WIN0 + 8'(i), b, err);
      q[8*i+:8] = b;
    end
    wr(PMG_IDX_CONFIG, 8'h00);
  endtask : read_burst

  // Burn request; broken slips a foreign write in to spoil the sequence
  task automatic burn(input logic broken);
    wr(PMG_IDX_KEYH, PMG_KEY_HIGH);
    wr(PMG_IDX_KEYL, PMG_KEY_LOW);
    if (broken)
      wr(PMG_IDX_OPMODE, {6'h00, PMG_OP_ACTIVE});
    wr(PMG_IDX_BASE, PMG_BURN_ARM);
    wr(PMG_IDX_BASE, PMG_BURN_GO);
  endtask : burn

  task automatic wait_irq(input int lim, output logic seen);
    seen = 1'b0;
    for (int n = 0; n < lim && !seen; n++)
    begin
      @(posedge clk_i);
      seen = (interrupt_out_n_i === 1'b0);
    end
  endtask : wait_irq
endmodule : pmg_apb_host

// ==== tb/pmg_gateway_tb_top.sv ====
// Self-checking bench for the parameter memory gateway
`timescale 1ns/100ps
module pmg_gateway_tb_top
  import pmg_pkg::*;
();
  // Short sleep delay keeps the run brief
  localparam int SLP = 20;
  localparam int LIMIT = 30000;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic factory_restore = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] exp_mem [128];
  logic [7:0] b;
  logic e, seen;
  logic [63:0] d;
  logic [6:0] base;

  // Clock at 125 MHz
  always #4 core_clk = ~core_clk;

  pmg_gateway #(.SLEEP_APPLY_CYC(SLP)) i_dut (
    .core_clk_i(core_clk), .srst_i(srst), .factory_restore_i(factory_restore),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .interrupt_out_n_o(irq_n)
  );

  pmg_apb_host i_host (
    .clk_i(core_clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .interrupt_out_n_i(irq_n)
  );

  // Expected factory byte, own copy of the pattern
  function automatic logic [7:0] fact_byte(input logic [6:0] a);
    fact_byte = {1'b0, a} ^ 8'h5A;
  endfunction : fact_byte

  // Expected status after n burns: valid only for one to three
  function automatic logic [7:0] stat_exp(input int n);
    stat_exp = {4'h0, (n > 0 && n < 4), 3'(n)};
  endfunction : stat_exp

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
    check_count++;
    if (seen_v !== exp_v)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : chk

  // Write burst and track what the shadow should hold
  task automatic wburst(input logic [6:0] bs, input logic [63:0] dv, input logic [1:0] gm);
    i_host.write_burst(bs, dv, gm);
    if (gm == PMG_GW_ON)
      for (int i = 0; i < 8; i++)
        exp_mem[bs + 7'(i)] = dv[8*i+:8];
  endtask : wburst

  task automatic burst_chk(input logic [6:0] bs);
    logic [63:0] got;
    i_host.read_burst(bs, got);
    for (int i = 0; i < 8; i++)
      chk("shadow byte", got[8*i+:8], exp_mem[bs + 7'(i)]);
  endtask : burst_chk

  // Sixteen bursts cover the whole shadow
  task automatic check_all();
    for (int k = 0; k < 16; k++)
      burst_chk(7'(k * 8));
  endtask : check_all

  // Mid-run reset; reload needs 128 cycles, so 130 are allowed
  task automatic reset_dut();
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (130) @(posedge core_clk);
  endtask : reset_dut

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(32'h0000_34ae));
    repeat (12) @(posedge core_clk);
    chk("pin in reset", 8'(irq_n), 8'h01);
    srst <= 1'b0;
    factory_restore <= 1'b0;
    repeat (130) @(posedge core_clk);
    i_host.rd(PMG_IDX_STATUS, b, e);
    chk("fresh status", b, stat_exp(0));
    for (int a = 0; a < 128; a++)
      exp_mem[a] = fact_byte(7'(a));
    check_all();
    // Unmapped index must be refused
    i_host.rd(8'h30, b, e);
    chk("unmapped err", 8'(e), 8'h01);
    chk("unmapped data", b, 8'h00);
    // One random burst in Active, Doze and Sleep
    for (int m = 0; m < 3; m++)
    begin
      i_host.wr(PMG_IDX_OPMODE, 8'(m));
      d = {$urandom, $urandom};
      base = 7'($urandom_range(15) * 8);
      wburst(base, d, PMG_GW_ON);
      i_host.wait_irq(SLP + 40, seen);
      chk("done pin", 8'(seen), 8'(m < 2));
      i_host.rd(PMG_IDX_IRQ, b, e);
      chk("irq source", b, (m < 2) ? 8'h20 : 8'h00);
      repeat (2) @(posedge core_clk);
      #1;
      chk("pin cleared", 8'(irq_n), 8'h01);
      i_host.rd(PMG_IDX_IRQ, b, e);
      chk("irq cleared", b, 8'h00);
      burst_chk(base);
    end
    i_host.wr(PMG_IDX_OPMODE, 8'h00);
    // Reserved gateway codes must leave the shadow alone
    for (int g = 2; g < 4; g++)
    begin
      wburst(base, ~d, 2'(g));
      i_host.wait_irq(40, seen);
      chk("reserved pin", 8'(seen), 8'h00);
      burst_chk(base);
    end
    // Fill the whole shadow before any burn
    for (int k = 0; k < 16; k++)
    begin
      wburst(7'(k * 8), {$urandom, $urandom}, PMG_GW_ON);
      i_host.wait_irq(40, seen);
      i_host.rd(PMG_IDX_IRQ, b, e);
      chk("burst done", b, 8'h20);
    end
    // Spoiled sequence must not burn
    i_host.burn(1'b1);
    i_host.wait_irq(300, seen);
    chk("spoiled burn", 8'(seen), 8'h00);
    i_host.rd(PMG_IDX_STATUS, b, e);
    chk("status unburnt", b, stat_exp(0));
    // Four burns, each followed by a reset and reload
    for (int n = 1; n < 5; n++)
    begin
      i_host.burn(1'b0);
      i_host.wait_irq(400, seen);
      chk("burn pin", 8'(seen), 8'h01);
      i_host.rd(PMG_IDX_IRQ, b, e);
      chk("burn irq", b, 8'h40);
      i_host.rd(PMG_IDX_STATUS, b, e);
      chk("burn status", b, stat_exp(n));
      if (n == 4)
        for (int a = 0; a < 128; a++)
          exp_mem[a] = fact_byte(7'(a));
      // Scribble one burst so only a reload can restore it
      i_host.write_burst(7'h00, {$urandom, $urandom}, PMG_GW_ON);
      i_host.wait_irq(40, seen);
      i_host.rd(PMG_IDX_IRQ, b, e);
      reset_dut();
      check_all();
    end
    complete_run();
  end
endmodule : pmg_gateway_tb_top
